//--- rtl/wps_pkg.sv
package wps_pkg;

    // Serial word geometry
    localparam int BITS_PER_BYTE = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam int WIPER_W = 10;
    localparam int TAP_COUNT = 1024;
    localparam int SLOT_COUNT = 4;
    localparam int SLOT_W = 2;

    // Address byte layout: type field, select pins, direction bit
    localparam int TYPE_HI = 7;
    localparam int TYPE_LO = 4;
    localparam int SEL_HI = 2;
    localparam int SEL_LO = 1;
    localparam int DIR_BIT = 0;
    // Arbitrary neutral type code, not tied to any real part
    localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'ha;

    // Instruction byte layout
    localparam int OPC_HI = 7;
    localparam int OPC_LO = 5;
    localparam int PTR_HI = 3;
    localparam int PTR_LO = 2;
    localparam logic [2:0] OPC_100 = 3'h4;
    localparam logic [2:0] OPC_101 = 3'h5;
    localparam logic [2:0] OPC_110 = 3'h6;
    localparam logic [2:0] OPC_111 = 3'h7;

    // Reset contents of the stored slots and the wiper
    localparam logic [9:0] SLOT_RESET = 10'h000;
    localparam logic [9:0] WIPER_RESET = 10'h000;

    // Nonvolatile write time, within the 10 ms ceiling
    localparam int CLK_MHZ = 50;
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;

    // Protocol states, Gray along idle-addr-instr-rx-tx-done
    typedef enum logic [2:0] {
        WPS_IDLE = 3'b000,
        WPS_ADDR = 3'b001,
        WPS_INSTR = 3'b011,
        WPS_RX = 3'b010,
        WPS_TX = 3'b110,
        WPS_DONE = 3'b111,
        WPS_IGNORE = 3'b101
    } wps_state_t;

    // Decoded command carried from instruction byte to completion
    typedef struct packed {
        logic rd;
        logic [2:0] opc;
        logic [1:0] ptr;
    } wps_cmd_t;

endpackage : wps_pkg

//--- rtl/wps_slave.sv
// Overview of operation
// - Capture every incoming bit on the rising serial clock edge.
// - Change transmitted data bits only after a falling serial clock edge.
// - Data line is open drain: pull low or release, never drive high.
// - Two select pins set two bits of the eight-bit slave address.
// - Join a transaction only when address bits match the select pins.
// - Write-block pin low refuses every nonvolatile slot write.
// - Decode the ten-bit wiper position into one of 1024 tap selects.
// - Tap decode is strictly one-hot, never two taps at once.
// - After power-up the wiper loads from default slot zero.
// - Host can read and write the wiper and every stored slot.
// - Data line changes only while serial clock is low.
// - Watch both lines for start; respond to nothing before one.
// - Master alone clocks and starts transfers; device is only a slave.
// - Transmitter releases the data line after eight bits for acknowledge.
// - Ninth clock per byte; receiver holds data low to acknowledge.
// - Acknowledge a matching address and a correctly received command byte.
// - Acknowledge data bytes that follow the command byte.
// - Stop after a nonvolatile write starts the write and disables inputs.
// - While writing internally, withhold acknowledge to the polling address.
// - After the write completes, acknowledge the polling address again.
// - Upper four address bits are a fixed type field; mismatch misses.
// - Address byte low bit gives direction, high reads, low writes.
// - Two pointer bits in the command byte select one of four slots.
// - A stored slot change completes within ten milliseconds.
`timescale 1ns/1ps

module wps_slave #(
    parameter int WRITE_CYCLES = wps_pkg::WRITE_CYCLES,
    parameter logic [3:0] DEVICE_TYPE = wps_pkg::DEVICE_TYPE_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic [1:0] addr_select_pins,
    input wire logic write_block_n,
    output logic [wps_pkg::WIPER_W-1:0] wiper_position_reg,
    output logic [wps_pkg::TAP_COUNT-1:0] tap_sel,
    output logic nv_busy
);

    localparam int WCNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(WRITE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: bit capture on the serial clock itself

    logic bit_val_q;
    logic bit_tgl_q;

    // Value held until the next rising edge, so the toggle crossing is safe
    always_ff @(posedge scl or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_val_q <= 1'b0;
            bit_tgl_q <= 1'b0;
        end
        else
        begin
            bit_val_q <= sda_i;
            bit_tgl_q <= ~bit_tgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers into the reference clock domain

    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic [1:0] tgl_s_q;
    logic [1:0] wb_s_q;
    logic [1:0] sel0_s_q;
    logic [1:0] sel1_s_q;
    logic scl_p_q;
    logic sda_p_q;
    logic tgl_p_q;

    // Two flops each; the second stage, plus a third edge flop for scl, sda and toggle, feeds the logic
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            tgl_s_q <= 2'h0;
            wb_s_q <= 2'h3;
            sel0_s_q <= 2'h0;
            sel1_s_q <= 2'h0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            tgl_p_q <= 1'b0;
        end
        else
        begin
            scl_s_q <= {scl_s_q[0], scl};
            sda_s_q <= {sda_s_q[0], sda_i};
            tgl_s_q <= {tgl_s_q[0], bit_tgl_q};
            wb_s_q <= {wb_s_q[0], write_block_n};
            sel0_s_q <= {sel0_s_q[0], addr_select_pins[0]};
            sel1_s_q <= {sel1_s_q[0], addr_select_pins[1]};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
            tgl_p_q <= tgl_s_q[1];
        end
    end

    logic start_ev;
    logic stop_ev;
    logic bit_ev;
    logic scl_fall;
    logic [1:0] sel_pins;

    // Line events; start and stop only count while the clock is high
    assign start_ev = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    assign stop_ev = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
    assign bit_ev = tgl_s_q[1] ^ tgl_p_q;
    assign scl_fall = scl_p_q & ~scl_s_q[1];
    assign sel_pins = {sel1_s_q[1], sel0_s_q[1]};

    ////////////////////////////////////////////////////////////////////////////
    // Protocol engine

    wps_pkg::wps_state_t state_q;
    wps_pkg::wps_cmd_t cmd_q;
    logic [wps_pkg::BIT_CNT_W-1:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] rx_lo_q;
    logic byte_idx_q;
    logic [7:0] tx_byte_q;
    logic [7:0] tx_hi_q;
    logic tx_on_q;
    logic ack_q;
    logic nv_pend_q;
    logic [wps_pkg::SLOT_W-1:0] nv_ptr_q;
    logic [wps_pkg::WIPER_W-1:0] nv_data_q;
    logic wip_ld_q;
    logic [wps_pkg::WIPER_W-1:0] wip_val_q;
    logic [wps_pkg::WIPER_W-1:0] slot_q [wps_pkg::SLOT_COUNT];
    logic busy_q;

    logic [7:0] byte_in;
    wps_pkg::wps_cmd_t cmd_in;
    logic addr_hit;
    logic [wps_pkg::WIPER_W-1:0] rd_val;

    assign byte_in = {sh_q[6:0], bit_val_q};
    assign cmd_in = '{rd: cmd_q.rd, opc: byte_in[wps_pkg::OPC_HI:wps_pkg::OPC_LO],
                      ptr: byte_in[wps_pkg::PTR_HI:wps_pkg::PTR_LO]};
    // Busy blocks the address match, so polling gets no acknowledge
    assign addr_hit = (byte_in[wps_pkg::TYPE_HI:wps_pkg::TYPE_LO] == DEVICE_TYPE)
                      && (byte_in[wps_pkg::SEL_HI:wps_pkg::SEL_LO] == sel_pins)
                      && !busy_q;
    // Read source: wiper for opcode 100, else the pointed slot
    assign rd_val = (cmd_in.opc == wps_pkg::OPC_100) ? wiper_position_reg : slot_q[cmd_in.ptr];

    // One decision per byte at its eighth bit; ninth bit is the ack clock
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= wps_pkg::WPS_IDLE;
            cmd_q <= '0;
            cnt_q <= '0;
            sh_q <= 8'h00;
            rx_lo_q <= 8'h00;
            byte_idx_q <= 1'b0;
            tx_byte_q <= 8'h00;
            tx_hi_q <= 8'h00;
            tx_on_q <= 1'b0;
            ack_q <= 1'b0;
            nv_pend_q <= 1'b0;
            nv_ptr_q <= '0;
            nv_data_q <= '0;
            wip_ld_q <= 1'b0;
            wip_val_q <= '0;
        end
        else
        begin
            wip_ld_q <= 1'b0;
            if (start_ev)
            begin
                state_q <= wps_pkg::WPS_ADDR;
                cnt_q <= '0;
                tx_on_q <= 1'b0;
                ack_q <= 1'b0;
                nv_pend_q <= 1'b0;
            end
            else if (stop_ev)
            begin
                state_q <= wps_pkg::WPS_IDLE;
                cnt_q <= '0;
                tx_on_q <= 1'b0;
                ack_q <= 1'b0;
                nv_pend_q <= 1'b0;
            end
            else if (bit_ev && state_q != wps_pkg::WPS_IDLE)
            begin
                if (cnt_q == wps_pkg::ACK_SLOT)
                begin
                    // Ack clock: for device-sent bytes, read master's answer; own ack is no answer
                    cnt_q <= '0;
                    ack_q <= 1'b0;
                    if (state_q == wps_pkg::WPS_TX && !ack_q)
                    begin
                        if (!bit_val_q && !byte_idx_q)
                        begin
                            byte_idx_q <= 1'b1;
                            tx_byte_q <= tx_hi_q;
                        end
                        else
                        begin
                            tx_on_q <= 1'b0;
                            state_q <= wps_pkg::WPS_DONE;
                        end
                    end
                end
                else
                begin
                    sh_q <= byte_in;
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == wps_pkg::ACK_SLOT - 1'b1)
                    begin
                        ack_q <= 1'b0;
                        case (state_q)
                            wps_pkg::WPS_ADDR:
                            begin
                                if (addr_hit)
                                begin
                                    ack_q <= 1'b1;
                                    cmd_q.rd <= byte_in[wps_pkg::DIR_BIT];
                                    state_q <= wps_pkg::WPS_INSTR;
                                end
                                else
                                begin
                                    state_q <= wps_pkg::WPS_IGNORE;
                                end
                            end
                            wps_pkg::WPS_INSTR:
                            begin
                                cmd_q <= cmd_in;
                                byte_idx_q <= 1'b0;
                                ack_q <= 1'b1;
                                state_q <= wps_pkg::WPS_DONE;
                                if (cmd_in.rd && (cmd_in.opc == wps_pkg::OPC_100 || cmd_in.opc == wps_pkg::OPC_101))
                                begin
                                    // Low eight bits first, then the top two
                                    tx_byte_q <= rd_val[7:0];
                                    tx_hi_q <= {6'h00, rd_val[9:8]};
                                    tx_on_q <= 1'b1;
                                    state_q <= wps_pkg::WPS_TX;
                                end
                                else if (!cmd_in.rd && (cmd_in.opc == wps_pkg::OPC_101 ||
                                                         cmd_in.opc == wps_pkg::OPC_110))
                                begin
                                    state_q <= wps_pkg::WPS_RX;
                                end
                                else if (cmd_in.rd && cmd_in.opc == wps_pkg::OPC_110)
                                begin
                                    wip_ld_q <= 1'b1;
                                    wip_val_q <= slot_q[cmd_in.ptr];
                                end
                                else if (!cmd_in.rd && cmd_in.opc == wps_pkg::OPC_111)
                                begin
                                    nv_pend_q <= 1'b1;
                                    nv_ptr_q <= cmd_in.ptr;
                                    nv_data_q <= wiper_position_reg;
                                end
                                else
                                begin
                                    ack_q <= 1'b0;
                                    state_q <= wps_pkg::WPS_IGNORE;
                                end
                            end
                            wps_pkg::WPS_RX:
                            begin
                                ack_q <= 1'b1;
                                if (!byte_idx_q)
                                begin
                                    rx_lo_q <= byte_in;
                                    byte_idx_q <= 1'b1;
                                end
                                else if (cmd_q.opc == wps_pkg::OPC_101)
                                begin
                                    wip_ld_q <= 1'b1;
                                    wip_val_q <= {byte_in[1:0], rx_lo_q};
                                    state_q <= wps_pkg::WPS_DONE;
                                end
                                else
                                begin
                                    // Slot write is held until the closing stop
                                    nv_pend_q <= 1'b1;
                                    nv_ptr_q <= cmd_q.ptr;
                                    nv_data_q <= {byte_in[1:0], rx_lo_q};
                                    state_q <= wps_pkg::WPS_DONE;
                                end
                            end
                            default:
                            begin
                                ack_q <= 1'b0;
                            end
                        endcase
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain data line, updated after a falling clock edge and released on start or stop

    logic drive_n_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive_n_q <= 1'b1;
        end
        else if (start_ev || stop_ev)
        begin
            drive_n_q <= 1'b1;
        end
        else if (scl_fall)
        begin
            if (cnt_q == wps_pkg::ACK_SLOT)
            begin
                drive_n_q <= ~ack_q;
            end
            else if (tx_on_q)
            begin
                drive_n_q <= tx_byte_q[3'h7 - cnt_q[2:0]];
            end
            else
            begin
                drive_n_q <= 1'b1;
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n = drive_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // Nonvolatile write timer and slot storage

    logic [WCNT_W-1:0] wcnt_q;
    logic wr_go;

    // A refused write never starts the timer, so polling acks at once
    assign wr_go = stop_ev && nv_pend_q && wb_s_q[1];

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            wcnt_q <= '0;
        end
        else if (wr_go)
        begin
            busy_q <= 1'b1;
            wcnt_q <= WCNT_LAST;
        end
        else if (busy_q)
        begin
            if (wcnt_q == '0)
            begin
                busy_q <= 1'b0;
            end
            else
            begin
                wcnt_q <= wcnt_q - 1'b1;
            end
        end
    end

    // Slot is written at the end of the write time
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < wps_pkg::SLOT_COUNT; i++)
            begin
                slot_q[i] <= wps_pkg::SLOT_RESET;
            end
        end
        else if (busy_q && wcnt_q == '0)
        begin
            slot_q[nv_ptr_q] <= nv_data_q;
        end
    end

    assign nv_busy = busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wiper position and tap decode

    logic recall_q;

    // Reset takes a constant; the recall copy happens on the first clock
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            recall_q <= 1'b1;
            wiper_position_reg <= wps_pkg::WIPER_RESET;
        end
        else if (recall_q)
        begin
            recall_q <= 1'b0;
            wiper_position_reg <= slot_q[0];
        end
        else if (wip_ld_q)
        begin
            wiper_position_reg <= wip_val_q;
        end
    end

    // Each tap compares its own index, so only one can ever match
    for (genvar t = 0; t < wps_pkg::TAP_COUNT; t++)
    begin : g_tap
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                tap_sel[t] <= (t == 0);
            end
            else
            begin
                tap_sel[t] <= (wiper_position_reg == wps_pkg::WIPER_W'(t));
            end
        end
    end

endmodule : wps_slave

//--- test/wps_bus_master.sv
`timescale 1ns/1ps

// Two-wire master paced by its own link clock; the serial clock parks high between frames
module wps_bus_master (
    input wire logic lclk,
    input wire logic sda_i,
    output logic scl,
    output logic m_oe_n
);
    // Idle bus: clock high, data released to the pull-up
    initial
    begin
        scl = 1'b1;
        m_oe_n = 1'b1;
    end

    task wait_l(input int n);
        repeat (n) @(posedge lclk);
    endtask : wait_l

    ////////////////////////////////////////////////////////////////////////
    // Data falls under a high clock; doubles as repeated start
    task start_c();
        m_oe_n <= 1'b1;
        wait_l(2);
        scl <= 1'b1;
        wait_l(5);
        m_oe_n <= 1'b0;
        wait_l(5);
        scl <= 1'b0;
    endtask : start_c

    // Data rises under a high clock
    task stop_c();
        m_oe_n <= 1'b0;
        wait_l(2);
        scl <= 1'b1;
        wait_l(5);
        m_oe_n <= 1'b1;
        wait_l(5);
    endtask : stop_c

    // Data set mid low phase, sampled late in the high phase
    task bit_c(input logic b, output logic r);
        wait_l(2);
        m_oe_n <= b;
        wait_l(3);
        scl <= 1'b1;
        wait_l(5);
        r = sda_i;
        scl <= 1'b0;
    endtask : bit_c

    // Eight bits MSB first, then the acknowledge clock
    task byte_c(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_c(d[i], r[i]);
        bit_c(ack_in, ack);
    endtask : byte_c
endmodule : wps_bus_master

//--- test/wps_slave_checker.sv
`timescale 1ns/1ps

module wps_slave_checker #(
    parameter int WRITE_CYCLES = wps_pkg::WRITE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic [1:0] addr_select_pins,
    input wire logic write_block_n,
    input wire logic [wps_pkg::WIPER_W-1:0] wiper_position_reg,
    input wire logic [wps_pkg::TAP_COUNT-1:0] tap_sel,
    input wire logic nv_busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic sda_prev_q;
    logic seen_start_q;
    int busy_cnt_q;

    // Raw start detector; before any start the device has no business on the line
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_prev_q <= 1'b1;
            seen_start_q <= 1'b0;
        end
        else
        begin
            sda_prev_q <= sda_i;
            seen_start_q <= seen_start_q | (sda_prev_q & ~sda_i & scl);
        end
    end

    // Length of the current busy stretch
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= nv_busy ? busy_cnt_q + 1 : 0;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_busy_done;
        nv_busy ##1 !nv_busy;
    endsequence

    a_open_drain: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    a_tap_onehot: assert property ($onehot(tap_sel))
        else $error("tap select not one-hot");
    a_tap_decode: assert property (tap_sel == ({{(wps_pkg::TAP_COUNT-1){1'b0}}, 1'b1} << $past(wiper_position_reg)))
        else $error("tap select does not follow wiper");
    a_pull_after_fall: assert property ($fell(sda_oe_n) |-> !scl && !$past(scl, 2))
        else $error("data pulled low outside clock low");
    a_quiet_before: assert property (!seen_start_q |-> sda_oe_n)
        else $error("data pulled before any start");
    a_busy_silent: assert property (nv_busy |-> sda_oe_n)
        else $error("acknowledge during internal write");
    a_busy_span: assert property (s_busy_done |-> busy_cnt_q >= WRITE_CYCLES - 1 && busy_cnt_q <= WRITE_CYCLES + 1)
        else $error("internal write length wrong");
    a_block_write: assert property ($rose(nv_busy) |-> write_block_n)
        else $error("write started while blocked");
    a_wiper_frozen: assert property (nv_busy && $past(nv_busy) |-> $stable(wiper_position_reg))
        else $error("wiper moved during internal write");
endmodule : wps_slave_checker

bind wps_slave wps_slave_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_select_pins(addr_select_pins), .write_block_n(write_block_n),
    .wiper_position_reg(wiper_position_reg), .tap_sel(tap_sel), .nv_busy(nv_busy)
);

//--- test/tb_wps_slave.sv
`timescale 1ns/1ps

module tb_wps_slave;
    localparam int WCYC = 1500;
    logic ref_clk = 1'b0;
    logic lclk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr_select_pins = 2'h0;
    logic write_block_n = 1'b1;
    logic scl, m_oe_n, sda_o, sda_oe_n, nv_busy, sda_i;
    logic [wps_pkg::WIPER_W-1:0] wiper_position_reg;
    logic [wps_pkg::TAP_COUNT-1:0] tap_sel;
    logic [9:0] slots [4];
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 69143;

    // System clock, and a link clock unrelated in phase
    always #10 ref_clk = ~ref_clk;
    initial
    begin
        #7;
        forever #24 lclk = ~lclk;
    end
    // Pulled-up wire: low while either side pulls it
    assign sda_i = sda_oe_n & m_oe_n;

    wps_slave #(.WRITE_CYCLES(WCYC)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .addr_select_pins(addr_select_pins), .write_block_n(write_block_n),
        .wiper_position_reg(wiper_position_reg), .tap_sel(tap_sel), .nv_busy(nv_busy));
    wps_bus_master i_master (.lclk(lclk), .sda_i(sda_i), .scl(scl), .m_oe_n(m_oe_n));

    ////////////////////////////////////////////////////////////////////////
    task check(input logic [wps_pkg::TAP_COUNT-1:0] seen, input logic [wps_pkg::TAP_COUNT-1:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task conclude();
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Hang guard, sized well above the expected run
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            err_count++;
            conclude();
        end
    end

    function automatic logic [wps_pkg::TAP_COUNT-1:0] onehot(input logic [9:0] v);
        onehot = '0;
        onehot[v] = 1'b1;
    endfunction : onehot

    function automatic logic [7:0] addr_b(input logic rd, input logic [1:0] sel);
        return {wps_pkg::DEVICE_TYPE_DEFAULT, 1'b0, sel, rd};
    endfunction : addr_b

    task put(input logic [7:0] d, input logic exp_n);
        logic [7:0] r;
        logic a;
        i_master.byte_c(d, 1'b1, r, a);
        check(a, exp_n);
    endtask : put

    task cmd(input logic rd, input logic [2:0] opc, input logic [1:0] ptr);
        i_master.start_c();
        put(addr_b(rd, addr_select_pins), 1'b0);
        put({opc, 1'b0, ptr, 2'h0}, 1'b0);
    endtask : cmd

    // Low byte first; a wiper value lands before the stop, a slot value only after it
    task put_val(input logic [9:0] v);
        put(v[7:0], 1'b0);
        put({6'h0, v[9:8]}, 1'b0);
        i_master.stop_c();
        repeat (4) @(posedge ref_clk);
    endtask : put_val

    task get_val(input logic [9:0] exp);
        logic [7:0] lo, hi;
        logic a;
        i_master.byte_c(8'hff, 1'b0, lo, a);
        i_master.byte_c(8'hff, 1'b1, hi, a);
        i_master.stop_c();
        check({hi, lo}, {6'h0, exp});
    endtask : get_val

    // The first poll lands inside the write and must be refused
    task poll();
        logic [7:0] r;
        logic a;
        int n;
        n = 0;
        a = 1'b1;
        while (a && n < 40)
        begin
            i_master.start_c();
            i_master.byte_c(addr_b(1'b0, addr_select_pins), 1'b1, r, a);
            i_master.stop_c();
            if (n == 0)
                check(a, 1'b1);
            n++;
        end
        check(a, 1'b0);
    endtask : poll

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [9:0] v;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check(wiper_position_reg, wps_pkg::SLOT_RESET);
        check(tap_sel, onehot(wps_pkg::SLOT_RESET));
        // Random wiper values at random select pins, the top code first
        for (int k = 0; k < 6; k++)
        begin
            @(posedge ref_clk);
            addr_select_pins <= 2'($random(seed));
            v = (k == 0) ? 10'h3ff : 10'($random(seed));
            repeat (6) @(posedge ref_clk);
            cmd(1'b0, wps_pkg::OPC_101, 2'h0);
            put_val(v);
            check(wiper_position_reg, v);
            check(tap_sel, onehot(v));
            cmd(1'b1, wps_pkg::OPC_100, 2'h0);
            get_val(v);
        end
        // Wrong select bits, then wrong type field
        i_master.start_c();
        put(addr_b(1'b0, ~addr_select_pins), 1'b1);
        put(8'h00, 1'b1);
        i_master.stop_c();
        i_master.start_c();
        put(addr_b(1'b0, addr_select_pins) ^ 8'h80, 1'b1);
        i_master.stop_c();
        // Undefined opcode: command byte not acknowledged
        i_master.start_c();
        put(addr_b(1'b0, addr_select_pins), 1'b0);
        put(8'h00, 1'b1);
        i_master.stop_c();
        // Every slot written, polled, read back
        for (int k = 0; k < 4; k++)
        begin
            slots[k] = 10'($random(seed));
            cmd(1'b0, wps_pkg::OPC_110, 2'(k));
            put_val(slots[k]);
            poll();
            cmd(1'b1, wps_pkg::OPC_101, 2'(k));
            get_val(slots[k]);
        end
        // Blocked write leaves slot one alone
        @(posedge ref_clk);
        write_block_n <= 1'b0;
        cmd(1'b0, wps_pkg::OPC_110, 2'h1);
        put_val(~slots[1]);
        repeat (20) @(posedge ref_clk);
        check(nv_busy, 1'b0);
        cmd(1'b1, wps_pkg::OPC_101, 2'h1);
        get_val(slots[1]);
        @(posedge ref_clk);
        write_block_n <= 1'b1;
        // Slot two to wiper, wiper to slot three
        cmd(1'b1, wps_pkg::OPC_110, 2'h2);
        i_master.stop_c();
        check(wiper_position_reg, slots[2]);
        cmd(1'b0, wps_pkg::OPC_111, 2'h3);
        i_master.stop_c();
        poll();
        cmd(1'b1, wps_pkg::OPC_101, 2'h3);
        get_val(slots[2]);
        // Repeated start after one data byte drops the command
        cmd(1'b0, wps_pkg::OPC_101, 2'h0);
        put(~slots[2][7:0], 1'b0);
        i_master.start_c();
        i_master.stop_c();
        check(wiper_position_reg, slots[2]);
        conclude();
    end
endmodule : tb_wps_slave
